// file: core_status_and_option_regs.sv
// Status and option register logic of the 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_defs.svh"

// Contract
// RL1: Wake flag bit 7 reads 1 after pin-change wake reset, else 0.
// RL2: ALU-affected zero, digit carry, carry ignore the status write; ALU result sets them.
// RL3: Time-out and power-down flags ignore all instruction writes.
// RL4: Clear-file on status zeroes top three bits, sets Z, keeps the rest.
// RL5: Software should alter status only by bit-clear, bit-set or move-to-file.
// RL6: Power-down flag set by power-up or watchdog clear, cleared by sleep.
// RL7: Zero flag follows whether the arithmetic or logic result is zero.
// RL8: Rotate right loads carry with operand LSB, rotate left with MSB.
// RL9: Option register is 8 bits, write-only from software.
// RL10: Option-load instruction copies the whole accumulator into option.
// RL11: Any reset sets all eight option bits to one.
// RL12: Unimplemented bit 6 of status reads zero.
// RL13: Pin, watchdog and wake resets are non-power-up resets.
// RL14: Page select bit 5 supplies program counter bit 9 on a jump.
// RL15: Reset clears the page select bit, selecting page 0.
// RL16: Time-out flag set by power-up, watchdog clear, sleep; cleared by time-out.
// RL17: Digit carry is nibble carry for add, inverted nibble borrow for subtract.
module core_status_and_option_regs (
  // Clock and power-up reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Executing instruction
  input var core_regs_pkg::exec_t exec_in,
  // Option load from the accumulator
  input wire logic option_load_in,
  input wire logic [7:0] acc_in,
  // Power-state events and non-power-up reset
  input var core_regs_pkg::power_evt_t power_in,
  // Jump request
  input var core_regs_pkg::jump_t jump_in,
  // Register views
  output logic [7:0] status_out,
  output logic [7:0] option_out,
  output logic page_select_bit_out,
  // Instruction result and program counter load
  output logic [7:0] result_out,
  output logic result_valid_out,
  output logic pc_load_valid_out,
  output logic [9:0] pc_load_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [7:0] alu_result(input core_regs_pkg::alu_op_t op,
                                            input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
    logic [7:0] r;
    r = a;
    case (op)
      core_regs_pkg::ALU_ADD: r = a + b;
      core_regs_pkg::ALU_SUB: r = b - a;
      core_regs_pkg::ALU_AND: r = a & b;
      core_regs_pkg::ALU_IOR: r = a | b;
      core_regs_pkg::ALU_XOR: r = a ^ b;
      core_regs_pkg::ALU_CLR: r = 8'h00;
      core_regs_pkg::ALU_RR: r = {cin, a[7:1]};
      core_regs_pkg::ALU_RL: r = {a[6:0], cin};
      default: r = a;
    endcase
    return r;
  endfunction

  function automatic logic affects_zero(input core_regs_pkg::alu_op_t op);
    return (op == core_regs_pkg::ALU_ADD) || (op == core_regs_pkg::ALU_SUB) ||
           (op == core_regs_pkg::ALU_AND) || (op == core_regs_pkg::ALU_IOR) ||
           (op == core_regs_pkg::ALU_XOR) || (op == core_regs_pkg::ALU_CLR) ||
           (op == core_regs_pkg::ALU_MOVZ);
  endfunction

  function automatic logic affects_arith(input core_regs_pkg::alu_op_t op);
    return (op == core_regs_pkg::ALU_ADD) || (op == core_regs_pkg::ALU_SUB);
  endfunction

  function automatic logic affects_rotate(input core_regs_pkg::alu_op_t op);
    return (op == core_regs_pkg::ALU_RR) || (op == core_regs_pkg::ALU_RL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] status_ff;
  logic [7:0] option_ff;
  logic [7:0] result_ff;
  logic result_valid_ff;
  logic pc_load_valid_ff;
  logic [9:0] pc_load_ff;

  logic [7:0] nxt_status;
  logic [7:0] alu_val;
  logic z_flag;
  logic digit_carry_flag;
  logic c_flag;
  logic [4:0] nib_sum;
  logic [4:0] nib_diff;
  logic [8:0] full_sum;
  logic [8:0] full_diff;
  logic status_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Flag computation

  always_comb begin
    alu_val = alu_result(exec_in.op, exec_in.opnd_a, exec_in.opnd_b,
                         status_ff[`ST_CARRY_BIT]);
    nib_sum = {1'b0, exec_in.opnd_a[3:0]} + {1'b0, exec_in.opnd_b[3:0]};
    nib_diff = {1'b0, exec_in.opnd_b[3:0]} - {1'b0, exec_in.opnd_a[3:0]};
    full_sum = {1'b0, exec_in.opnd_a} + {1'b0, exec_in.opnd_b};
    full_diff = {1'b0, exec_in.opnd_b} - {1'b0, exec_in.opnd_a};
    z_flag = (alu_val == 8'h00); // RL7
    // Subtraction flags report the inverted borrow
    digit_carry_flag = (exec_in.op == core_regs_pkg::ALU_SUB) ? ~nib_diff[4] : nib_sum[4]; // RL17
    if (exec_in.op == core_regs_pkg::ALU_RR) begin
      c_flag = exec_in.opnd_a[0]; // RL8
    end else if (exec_in.op == core_regs_pkg::ALU_RL) begin
      c_flag = exec_in.opnd_a[7]; // RL8
    end else if (exec_in.op == core_regs_pkg::ALU_SUB) begin
      c_flag = ~full_diff[8];
    end else begin
      c_flag = full_sum[8];
    end
  end

  assign status_hit = exec_in.valid && exec_in.dest_file &&
                      (exec_in.file_addr == `STATUS_FILE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Status next value

  always_comb begin
    nxt_status = status_ff;
    // A non-power-up reset in the same cycle drops the instruction
    if (exec_in.valid && !power_in.soft_reset) begin
      if (status_hit) begin
        if (affects_zero(exec_in.op) || affects_arith(exec_in.op) ||
            affects_rotate(exec_in.op)) begin
          // Flag-driving op: only wake and page bits take the data, flags keep old value
          nxt_status = (status_ff & ~`STATUS_UPPER_WRITE_MASK) |
                       (alu_val & `STATUS_UPPER_WRITE_MASK); // RL2 RL3 RL4
        end else begin
          // Only wake, page and ALU flag bits take the written data
          nxt_status = (status_ff & ~`STATUS_WRITE_MASK) | (alu_val & `STATUS_WRITE_MASK); // RL3
        end
      end
      // Flags driven by the ALU override the written data
      if (affects_zero(exec_in.op)) begin
        nxt_status[`ST_ZERO_BIT] = z_flag; // RL2 RL4
      end
      if (affects_arith(exec_in.op)) begin
        nxt_status[`ST_DIGIT_CARRY_BIT] = digit_carry_flag; // RL2
        nxt_status[`ST_CARRY_BIT] = c_flag; // RL2
      end
      if (affects_rotate(exec_in.op)) begin
        nxt_status[`ST_CARRY_BIT] = c_flag; // RL2
      end
    end
    if (power_in.watchdog_clear_op) begin
      nxt_status[`ST_TIMEOUT_BIT] = 1'b1; // RL16
      nxt_status[`ST_POWERDOWN_BIT] = 1'b1; // RL6
    end
    if (power_in.sleep_op) begin
      nxt_status[`ST_TIMEOUT_BIT] = 1'b1; // RL16
      nxt_status[`ST_POWERDOWN_BIT] = 1'b0; // RL6
    end
    if (power_in.watchdog_timeout) begin
      nxt_status[`ST_TIMEOUT_BIT] = 1'b0; // RL16
    end
    if (power_in.soft_reset) begin
      // Non-power-up reset keeps power-down and ALU flags, rewrites wake and page, clears time-out on watchdog cause
      nxt_status[`ST_WAKE_BIT] = (power_in.cause == core_regs_pkg::CAUSE_WAKE); // RL1 RL13
      nxt_status[`ST_PAGE_BIT] = 1'b0; // RL15
      if (power_in.cause == core_regs_pkg::CAUSE_WATCHDOG) begin
        nxt_status[`ST_TIMEOUT_BIT] = 1'b0; // RL16
      end
    end
    nxt_status[`ST_UNUSED_BIT] = 1'b0; // RL12
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_ff <= `STATUS_POR_VALUE; // RL1 RL6 RL15 RL16
    end else begin
      status_ff <= nxt_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option register

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      option_ff <= `OPTION_RESET_VALUE; // RL11
    end else if (power_in.soft_reset) begin
      option_ff <= `OPTION_RESET_VALUE; // RL11 RL13
    end else if (option_load_in) begin
      option_ff <= acc_in; // RL9 RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction result

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_ff <= 8'h00;
      result_valid_ff <= 1'b0;
    end else begin
      result_ff <= alu_val;
      result_valid_ff <= exec_in.valid && !power_in.soft_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jump target

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_load_valid_ff <= 1'b0;
      pc_load_ff <= 10'h000;
    end else begin
      pc_load_valid_ff <= jump_in.valid;
      if (jump_in.valid) begin
        pc_load_ff <= {status_ff[`ST_PAGE_BIT], jump_in.target}; // RL14
      end
    end
  end

  assign status_out = status_ff;
  assign option_out = option_ff;
  assign page_select_bit_out = status_ff[`ST_PAGE_BIT];
  assign result_out = result_ff;
  assign result_valid_out = result_valid_ff;
  assign pc_load_valid_out = pc_load_valid_ff;
  assign pc_load_out = pc_load_ff;

endmodule

`default_nettype wire

// file: core_regs_defs.svh
// Offsets, field positions, reset values of the core status and option registers
`ifndef CORE_REGS_DEFS_SVH
`define CORE_REGS_DEFS_SVH

// Data-file address of the status register
`define STATUS_FILE_ADDR 5'h03

// Status register field positions
`define ST_WAKE_BIT 7
`define ST_UNUSED_BIT 6
`define ST_PAGE_BIT 5
`define ST_TIMEOUT_BIT 4
`define ST_POWERDOWN_BIT 3
`define ST_ZERO_BIT 2
`define ST_DIGIT_CARRY_BIT 1
`define ST_CARRY_BIT 0

// Power-up values; the three ALU flags power up undefined and are held at zero here
`define STATUS_POR_VALUE 8'h18
`define OPTION_RESET_VALUE 8'hff

// Bits that an instruction may write directly
`define STATUS_WRITE_MASK 8'ha7

// Bits that take written data when the instruction also drives the ALU flags
`define STATUS_UPPER_WRITE_MASK 8'ha0

`endif

// file: core_regs_pkg.sv
// Types shared by the core status and option register logic
`default_nettype none
package core_regs_pkg;

  // Operation applied by the executing instruction
  typedef enum logic [3:0] {
    ALU_PASS = 4'h0,
    ALU_ADD = 4'h1,
    ALU_SUB = 4'h2,
    ALU_AND = 4'h3,
    ALU_IOR = 4'h4,
    ALU_XOR = 4'h5,
    ALU_CLR = 4'h6,
    ALU_RR = 4'h7,
    ALU_RL = 4'h8,
    ALU_MOVZ = 4'h9
  } alu_op_t;

  // Cause of a non-power-up reset
  typedef enum logic [1:0] {
    CAUSE_PIN = 2'h0,
    CAUSE_WATCHDOG = 2'h1,
    CAUSE_WAKE = 2'h2
  } reset_cause_t;

  // One executing instruction
  typedef struct packed {
    logic valid;
    alu_op_t op;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic dest_file;
    logic [4:0] file_addr;
  } exec_t;

  // Power-state and reset events
  typedef struct packed {
    logic watchdog_clear_op;
    logic sleep_op;
    logic watchdog_timeout;
    logic soft_reset;
    reset_cause_t cause;
  } power_evt_t;

  // Jump request
  typedef struct packed {
    logic valid;
    logic [8:0] target;
  } jump_t;

endpackage
`default_nettype wire

// file: core_regs_chk.sv
// Assertion checker of the core status and option registers
`timescale 1ns/1ps
`default_nettype none
module core_regs_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Stimulus
  input var core_regs_pkg::exec_t exec_in,
  input wire logic option_load_in,
  input wire logic [7:0] acc_in,
  input var core_regs_pkg::power_evt_t power_in,
  input var core_regs_pkg::jump_t jump_in,
  // Observed outputs
  input wire logic [7:0] status_out,
  input wire logic [7:0] option_out,
  input wire logic page_select_bit_out,
  input wire logic [7:0] result_out,
  input wire logic pc_load_valid_out,
  input wire logic [9:0] pc_load_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire quiet = (power_in == '0);
  wire st_wr = exec_in.valid && exec_in.dest_file && (exec_in.file_addr == 5'h03);
  ////////////////////////////////////////
  a_unused_zero: assert property (status_out[6] == 1'b0) else $error("status bit 6 set");
  a_page_view: assert property (page_select_bit_out == status_out[5])
    else $error("page view differs");
  a_option_reset: assert property (power_in.soft_reset |=> option_out == 8'hff)
    else $error("option not all ones");
  a_option_load: assert property (option_load_in && !power_in.soft_reset
    |=> option_out == $past(acc_in)) else $error("option load lost");
  a_wake_cause: assert property (power_in.soft_reset |=> !status_out[5] &&
    status_out[7] == ($past(power_in.cause) == core_regs_pkg::CAUSE_WAKE))
    else $error("wake flag or page wrong");
  a_sleep_flags: assert property (power_in.sleep_op && !power_in.watchdog_timeout &&
    !power_in.soft_reset |=> status_out[4:3] == 2'b10) else $error("sleep flags wrong");
  a_flags_locked: assert property (st_wr && exec_in.op == core_regs_pkg::ALU_PASS && quiet
    |=> status_out[4:3] == $past(status_out[4:3]) && status_out[5] == $past(exec_in.opnd_a[5]))
    else $error("status write wrong");
  a_clear_status: assert property (st_wr && exec_in.op == core_regs_pkg::ALU_CLR && quiet
    |=> status_out[7:5] == 3'h0 && status_out[2] && status_out[4:3] == $past(status_out[4:3])
    && status_out[1:0] == $past(status_out[1:0])) else $error("clear of status wrong");
  a_zero_flag: assert property (exec_in.valid && exec_in.op == core_regs_pkg::ALU_ADD &&
    !exec_in.dest_file && quiet |=> status_out[2] == (result_out == 8'h00))
    else $error("zero flag wrong");
  a_jump_page: assert property (jump_in.valid |=> pc_load_valid_out &&
    pc_load_out == {$past(page_select_bit_out), $past(jump_in.target)}) else $error("jump wrong");
  c_clear: cover property (st_wr && exec_in.op == core_regs_pkg::ALU_CLR);
  c_wake: cover property (power_in.soft_reset && power_in.cause == core_regs_pkg::CAUSE_WAKE);
  c_jump: cover property (jump_in.valid && page_select_bit_out);
endmodule
bind core_status_and_option_regs core_regs_chk chk_u (.*);
`default_nettype wire

// file: testbench.sv
// Self-checking bench of the core status and option registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  core_regs_pkg::exec_t exec_in = '0;
  logic option_load_in = 1'b0;
  logic [7:0] acc_in = 8'h00;
  core_regs_pkg::power_evt_t power_in = '0;
  core_regs_pkg::jump_t jump_in = '0;
  logic [7:0] status_out, option_out, result_out;
  logic page_select_bit_out, result_valid_out, pc_load_valid_out;
  logic [9:0] pc_load_out;
  int miscompares = 0;
  int samples_checked = 0;
  always #10 clk_in = ~clk_in;
  core_status_and_option_regs dut_u (.*);
  ////////////////////////////////////////
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One instruction, with status as destination when dst is set
  task automatic ex(input core_regs_pkg::alu_op_t op, input logic [7:0] a, b,
      input logic dst, input logic [7:0] res, st);
    exec_in = '{1'b1, op, a, b, dst, 5'h03};
    step();
    exec_in = '0;
    chk(result_out, res);
    chk(result_valid_out, 1'b1);
    chk(status_out, st);
    step();
  endtask
  task automatic pw(input logic [5:0] evt, input logic [7:0] st);
    power_in = evt;
    step();
    power_in = '0;
    chk(status_out, st);
    chk(option_out, 8'hff);
    step();
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    chk(status_out, 8'h18);
    chk(option_out, 8'hff);
    option_load_in = 1'b1;
    acc_in = 8'h5a;
    step();
    option_load_in = 1'b0;
    chk(option_out, 8'h5a);
    pw(6'h04, 8'h18);
    pw(6'h06, 8'h98);
    pw(6'h05, 8'h08);
    pw(6'h20, 8'h18);
    pw(6'h10, 8'h10);
    pw(6'h08, 8'h00);
    pw(6'h20, 8'h18);
    $display("test power events done");
    ex(core_regs_pkg::ALU_PASS, 8'hff, 8'h00, 1'b1, 8'hff, 8'hbf);
    ex(core_regs_pkg::ALU_CLR, 8'h00, 8'h00, 1'b1, 8'h00, 8'h1f);
    ex(core_regs_pkg::ALU_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h1a);
    ex(core_regs_pkg::ALU_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h1f);
    ex(core_regs_pkg::ALU_SUB, 8'h01, 8'h10, 1'b0, 8'h0f, 8'h19);
    ex(core_regs_pkg::ALU_ADD, 8'hf0, 8'h10, 1'b1, 8'h00, 8'h1d);
    ex(core_regs_pkg::ALU_RL, 8'h01, 8'h00, 1'b0, 8'h03, 8'h1c);
    ex(core_regs_pkg::ALU_RR, 8'h01, 8'h00, 1'b0, 8'h00, 8'h1d);
    ex(core_regs_pkg::ALU_IOR, 8'hf0, 8'h0f, 1'b0, 8'hff, 8'h19);
    ex(core_regs_pkg::ALU_AND, 8'hf0, 8'h0f, 1'b0, 8'h00, 8'h1d);
    ex(core_regs_pkg::ALU_XOR, 8'h5a, 8'ha5, 1'b0, 8'hff, 8'h19);
    ex(core_regs_pkg::ALU_MOVZ, 8'h00, 8'h00, 1'b0, 8'h00, 8'h1d);
    $display("test instructions done");
    ex(core_regs_pkg::ALU_PASS, 8'h20, 8'h00, 1'b1, 8'h20, 8'h38);
    jump_in = '{1'b1, 9'h1ab};
    step();
    jump_in = '0;
    chk(pc_load_valid_out, 1'b1);
    chk(pc_load_out, 10'h3ab);
    rst_n_in = 1'b0;
    step();
    rst_n_in = 1'b1;
    chk(status_out, 8'h18);
    chk(page_select_bit_out, 1'b0);
    $display("test jump and reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
